/* File: logic/flash_host_pkg.sv */
`default_nettype none
package flash_host_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   // Unlock addresses and command bytes.
   localparam logic [18:0] UNLOCK_A = 19'h00555;
   localparam logic [18:0] UNLOCK_B = 19'h002aa;
   localparam logic [7:0] CMD_UNLOCK_A = 8'haa;
   localparam logic [7:0] CMD_UNLOCK_B = 8'h55;
   localparam logic [7:0] CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   localparam logic [7:0] CMD_IDENTIFY = 8'h90;
   localparam logic [7:0] CMD_RESET = 8'hf0;
   // Identification read offsets.
   localparam logic [18:0] ID_MAKER_A = 19'h00000;
   localparam logic [18:0] ID_DEVICE_A = 19'h00001;
   localparam logic [18:0] ID_PROTECT_OFS = 19'h00002;
   localparam int SECTOR_LSB = 16;
   // Operation codes on the user port.
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_PROGRAM = 3'h1;
   localparam logic [2:0] OP_CHIP_ERASE = 3'h2;
   localparam logic [2:0] OP_SECTOR_ERASE = 3'h3;
   localparam logic [2:0] OP_SUSPEND = 3'h4;
   localparam logic [2:0] OP_RESUME = 3'h5;
   localparam logic [2:0] OP_IDENTIFY = 3'h6;
   localparam logic [2:0] OP_RESET = 3'h7;
   // Bus cycle timing at 10 MHz.
   localparam int CLK_NS = 100;
   localparam int SETUP_NS = 100;
   localparam int STROBE_NS = 100;
   localparam int ACCESS_NS = 100;
   localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + 2;
   localparam int MAX_WRITES = 6;
endpackage
`default_nettype wire

/* File: logic/bus_cycle.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// One strobed bus cycle on the flash pins.
// ----------------------------------------
module bus_cycle (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic start,
   input wire logic is_read,
   input wire logic [18:0] addr,
   input wire logic [7:0] wdata,
   output logic done,
   output logic [7:0] rdata,
   output logic chip_sel_n,
   output logic out_en_n,
   output logic write_n,
   output logic [18:0] addr_pins,
   output logic [7:0] byte_bus_out,
   output logic byte_bus_oe_n,
   input wire logic [7:0] byte_bus_in
);
   typedef enum logic [1:0] {idle_s, setup_s, strobe_s, hold_s} cyc_t;
   cyc_t state;
   logic rd;
   logic [3:0] cnt;
   logic [7:0] sync1, sync2;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 8'h00;
         sync2 <= 8'h00;
      end else if (clk_en) begin
         sync1 <= byte_bus_in;
         sync2 <= sync1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= idle_s;
         cnt <= 4'h0;
         rd <= 1'b0;
         done <= 1'b0;
         rdata <= 8'h00;
         chip_sel_n <= 1'b1;
         out_en_n <= 1'b1;
         write_n <= 1'b1;
         addr_pins <= 19'h00000;
         byte_bus_out <= 8'h00;
         byte_bus_oe_n <= 1'b1;
      end else if (clk_en) begin
         done <= 1'b0;
         case (state)
            idle_s: begin
               if (start) begin
                  rd <= is_read;
                  addr_pins <= addr;
                  byte_bus_out <= wdata;
                  byte_bus_oe_n <= is_read;
                  cnt <= 4'(flash_host_pkg::SETUP_CYC);
                  state <= setup_s;
               end
            end
            setup_s: begin
               // Address settles first; strobes fall together afterwards.
               chip_sel_n <= 1'b0;
               if (rd) begin
                  out_en_n <= 1'b0;
                  cnt <= 4'(flash_host_pkg::ACCESS_CYC);
               end else begin
                  write_n <= 1'b0;
                  cnt <= 4'(flash_host_pkg::STROBE_CYC);
               end
               state <= strobe_s;
            end
            strobe_s: begin
               if (cnt > 4'h1) begin
                  cnt <= cnt - 4'h1;
               end else begin
                  if (rd) begin
                     rdata <= sync2;
                  end
                  // Data stays driven past the rising write strobe.
                  write_n <= 1'b1;
                  out_en_n <= 1'b1;
                  chip_sel_n <= 1'b1;
                  state <= hold_s;
               end
            end
            hold_s: begin
               byte_bus_oe_n <= 1'b1;
               done <= 1'b1;
               state <= idle_s;
            end
            default: state <= idle_s;
         endcase
      end
   end
endmodule // bus_cycle
`default_nettype wire

/* File: logic/flash_host.sv */
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Reads hold chip select and output enable low, write strobe high.
// - Command writes drive write strobe and chip select low, output enable high.
// - Protected sectors refuse program and erase; protect all before unprotect.
// - Program is AA/555, 55/2AA, A0/555, then byte at its address.
// - Chip erase is six writes ending with 10 to 555.
// - Sector erase ends with 30 written inside the sector.
// - Host writes reset to leave identification mode.
module flash_host (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic op_valid,
   output logic op_ready,
   input wire logic [2:0] op_code,
   input wire logic [18:0] op_addr,
   input wire logic [7:0] op_data,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic id_mode,
   output logic suspended,
   output logic chip_sel_n,
   output logic out_en_n,
   output logic write_n,
   output logic [18:0] addr_pins,
   output logic [7:0] byte_bus_out,
   output logic byte_bus_oe_n,
   input wire logic [7:0] byte_bus_in
);
   typedef enum logic [1:0] {idle_s, issue_s, wait_s} seq_t;
   seq_t state;
   logic [2:0] op;
   logic [18:0] target;
   logic [7:0] value;
   logic [2:0] idx;
   logic [2:0] last_idx;
   logic cyc_start;
   logic cyc_read;
   logic [18:0] cyc_addr;
   logic [7:0] cyc_data;
   logic cyc_done;
   logic [7:0] cyc_rdata;

   // ----------------------------------------
   // Step table for each command sequence.
   // ----------------------------------------
   always_comb begin
      last_idx = 3'h0;
      cyc_read = 1'b0;
      cyc_addr = target;
      cyc_data = value;
      case (op)
         flash_host_pkg::OP_READ: begin
            cyc_read = 1'b1;
         end
         flash_host_pkg::OP_RESET: cyc_data = flash_host_pkg::CMD_RESET;
         flash_host_pkg::OP_SUSPEND: cyc_data = flash_host_pkg::CMD_SUSPEND;
         flash_host_pkg::OP_RESUME: cyc_data = flash_host_pkg::CMD_RESUME;
         default: begin
            // Unlock prefix shared by all multi-cycle sequences.
            case (op)
               flash_host_pkg::OP_PROGRAM: last_idx = 3'h3;
               flash_host_pkg::OP_IDENTIFY: last_idx = 3'h3;
               default: last_idx = 3'h5;
            endcase
            case (idx)
               3'h0, 3'h3: begin
                  cyc_addr = flash_host_pkg::UNLOCK_A;
                  cyc_data = flash_host_pkg::CMD_UNLOCK_A;
               end
               3'h1, 3'h4: begin
                  cyc_addr = flash_host_pkg::UNLOCK_B;
                  cyc_data = flash_host_pkg::CMD_UNLOCK_B;
               end
               3'h2: begin
                  cyc_addr = flash_host_pkg::UNLOCK_A;
                  if (op == flash_host_pkg::OP_PROGRAM) begin
                     cyc_data = flash_host_pkg::CMD_PROGRAM;
                  end else if (op == flash_host_pkg::OP_IDENTIFY) begin
                     cyc_data = flash_host_pkg::CMD_IDENTIFY;
                  end else begin
                     cyc_data = flash_host_pkg::CMD_ERASE_SETUP;
                  end
               end
               default: begin
                  cyc_addr = flash_host_pkg::UNLOCK_A;
                  cyc_data = flash_host_pkg::CMD_CHIP_ERASE;
                  if (op == flash_host_pkg::OP_SECTOR_ERASE) begin
                     cyc_addr = target;
                     cyc_data = flash_host_pkg::CMD_SECTOR_ERASE;
                  end
               end
            endcase
            // No unprotect cycle is ever issued, so the protect order cannot break.
            // Program ends on the user address/byte; identification ends on a read of the user address.
            if ((op == flash_host_pkg::OP_PROGRAM) && (idx == 3'h3)) begin
               cyc_addr = target;
               cyc_data = value;
            end
            if ((op == flash_host_pkg::OP_IDENTIFY) && (idx == 3'h3)) begin
               cyc_addr = target;
               cyc_read = 1'b1;
            end
         end
      endcase
   end

   assign op_ready = (state == idle_s);

   // ----------------------------------------
   // Sequencer: one bus cycle per step.
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= idle_s;
         op <= flash_host_pkg::OP_READ;
         target <= 19'h00000;
         value <= 8'h00;
         idx <= 3'h0;
         cyc_start <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
      end else if (clk_en) begin
         cyc_start <= 1'b0;
         rsp_valid <= 1'b0;
         case (state)
            idle_s: begin
               if (op_valid) begin
                  op <= op_code;
                  target <= op_addr;
                  value <= op_data;
                  idx <= 3'h0;
                  state <= issue_s;
               end
            end
            issue_s: begin
               cyc_start <= 1'b1;
               state <= wait_s;
            end
            wait_s: begin
               if (cyc_done) begin
                  if (idx == last_idx) begin
                     rsp_data <= cyc_read ? cyc_rdata : 8'h00;
                     rsp_valid <= 1'b1;
                     idx <= 3'h0;
                     state <= idle_s;
                  end else begin
                     idx <= idx + 3'h1;
                     state <= issue_s;
                  end
               end
            end
            default: state <= idle_s;
         endcase
      end
   end

   // ----------------------------------------
   // Mode tracking of the device outside.
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         id_mode <= 1'b0;
         suspended <= 1'b0;
      end else if (clk_en && (state == wait_s) && cyc_done && (idx == last_idx)) begin
         case (op)
            flash_host_pkg::OP_IDENTIFY: id_mode <= 1'b1;
            flash_host_pkg::OP_RESET: id_mode <= 1'b0;
            flash_host_pkg::OP_SUSPEND: suspended <= 1'b1;
            flash_host_pkg::OP_RESUME: suspended <= 1'b0;
            default: id_mode <= id_mode;
         endcase
      end
   end

   bus_cycle u_cycle (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .start(cyc_start),
      .is_read(cyc_read),
      .addr(cyc_addr),
      .wdata(cyc_data),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .chip_sel_n(chip_sel_n),
      .out_en_n(out_en_n),
      .write_n(write_n),
      .addr_pins(addr_pins),
      .byte_bus_out(byte_bus_out),
      .byte_bus_oe_n(byte_bus_oe_n),
      .byte_bus_in(byte_bus_in)
   );
endmodule // flash_host
`default_nettype wire

/* File: tb/flash_device_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------
// Behavioural flash seen at its pins.
// ----------------------------------
module flash_device_model #(
   parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value.
   parameter logic [7:0] DEVICE_CODE = 8'h3c, // Arbitrary value.
   parameter logic [7:0] PROT_MASK = 8'h04
) (
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic write_n,
   input wire logic [18:0] addr_pins,
   input wire logic [7:0] byte_bus_out,
   output logic [7:0] byte_bus_in
);
   logic [7:0] mem [0:524287];
   logic [18:0] la;
   logic idm = 1'b0;
   logic ers = 1'b0;
   logic sus = 1'b0;
   int step = 0;
   wire logic wr = !(write_n || chip_sel_n);
   wire logic rd = !(out_en_n || chip_sel_n);
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      byte_bus_in = 8'h00;
   end
   always @(posedge rd) begin
      if (!idm) byte_bus_in = mem[addr_pins];
      else if (addr_pins[7:0] == 8'h00) byte_bus_in = MAKER_CODE;
      else if (addr_pins[7:0] == 8'h01) byte_bus_in = DEVICE_CODE;
      else byte_bus_in = {7'h00, addr_pins[7:0] == 8'h02 && PROT_MASK[addr_pins[18:16]]};
   end
   // A released bus shows the inverse of its last byte.
   always @(negedge rd) byte_bus_in = ~byte_bus_in;
   always @(posedge wr) la = addr_pins;
   always @(negedge wr) begin : cmd
      logic u1;
      logic u2;
      logic [7:0] d;
      d = byte_bus_out;
      u1 = la[15:0] == 16'h0555;
      u2 = la[15:0] == 16'h02aa;
      if (d == 8'hf0) begin
         step = 0;
         idm = 1'b0;
      end else case (step)
         0: begin
            if (d == 8'haa && u1) step = 1;
            else if (d == 8'hb0 && ers) sus = 1'b1;
            else if (d == 8'h30 && sus) {sus, ers} = 2'b00;
            else if (d == 8'h30 && ers) begin
               for (int i = 0; i < 65536; i++) begin
                  if (!PROT_MASK[la[18:16]]) mem[{la[18:16], 16'(i)}] = 8'hff;
               end
            end
         end
         1: step = (d == 8'h55 && u2) ? 2 : 0;
         2: begin
            if (u1 && d == 8'h90) idm = 1'b1;
            step = !u1 ? 0 : d == 8'ha0 ? 3 : d == 8'h80 ? 4 : 0;
         end
         3: begin
            if (!PROT_MASK[la[18:16]]) mem[la] = mem[la] & d;
            step = 0;
         end
         4: step = (d == 8'haa && u1) ? 5 : 0;
         5: step = (d == 8'h55 && u2) ? 6 : 0;
         default: begin
            for (int i = 0; i < 524288; i++) begin
               if (!PROT_MASK[i[18:16]] && (d == 8'h10 && u1 || d == 8'h30 && i[18:16] == la[18:16]))
                  mem[i] = 8'hff;
            end
            ers = d == 8'h30;
            step = 0;
         end
      endcase
   end
endmodule // flash_device_model
`default_nettype wire

/* File: tb/flash_host_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module flash_host_checker (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic op_valid,
   input wire logic op_ready,
   input wire logic [2:0] op_code,
   input wire logic rsp_valid,
   input wire logic id_mode,
   input wire logic suspended,
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic write_n,
   input wire logic [18:0] addr_pins,
   input wire logic [7:0] byte_bus_out,
   input wire logic byte_bus_oe_n
);
   logic [2:0] op;
   logic [2:0] nw;
   logic wr_q;
   wire logic take = clk_en && op_valid && op_ready;
   // Counts the write strobes of the operation in flight.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) op <= 3'h0;
      else if (take) op <= op_code;
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= 1'b1;
         nw <= 3'h0;
      end else begin
         wr_q <= write_n;
         if (take) nw <= 3'h0;
         else if (wr_q && !write_n) nw <= nw + 3'h1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   rd_strobe_a: assert property (!out_en_n |-> !chip_sel_n && write_n)
      else $error("read strobes wrong");
   wr_strobe_a: assert property (!write_n |-> !chip_sel_n && out_en_n)
      else $error("write strobes wrong");
   bus_turn_a: assert property (!out_en_n |-> byte_bus_oe_n)
      else $error("bus fight");
   data_hold_a: assert property ($rose(write_n) |-> $stable(byte_bus_out) && !byte_bus_oe_n)
      else $error("data not held");
   addr_hold_a: assert property (!chip_sel_n |-> $stable(addr_pins))
      else $error("address moved");
   prog_count_a: assert property (rsp_valid && op == 3'h1 |-> nw == 3'h4)
      else $error("program writes");
   erase_count_a: assert property (rsp_valid && op inside {3'h2, 3'h3} |-> nw == 3'h6)
      else $error("erase writes");
   id_entry_a: assert property (rsp_valid && op == 3'h6 |-> nw == 3'h3 && id_mode)
      else $error("identify entry");
   unlock_first_a: assert property ($fell(write_n) && nw == 3'h0 && op inside {3'h1, 3'h2, 3'h3, 3'h6}
      |-> addr_pins[10:0] == 11'h555 && byte_bus_out == 8'haa)
      else $error("first unlock wrong");
   suspend_flag_a: assert property (rsp_valid && op == 3'h4 |-> suspended)
      else $error("suspend flag");
   answer_due_a: assert property (take |-> ##[2:60] rsp_valid)
      else $error("no answer");
   freeze_pins_a: assert property (!clk_en |=> $stable(write_n) && $stable(chip_sel_n) && $stable(addr_pins) && $stable(rsp_valid))
      else $error("state moved while frozen");
   cover property (rsp_valid && op == 3'h3);
   cover property (rsp_valid && op == 3'h5);
   cover property (rsp_valid && op == 3'h6);
endmodule // flash_host_checker
bind flash_host flash_host_checker chk_u (.ref_clk, .rst_n, .clk_en, .op_valid, .op_ready,
   .op_code, .rsp_valid, .id_mode, .suspended, .chip_sel_n, .out_en_n, .write_n,
   .addr_pins, .byte_bus_out, .byte_bus_oe_n);
`default_nettype wire

/* File: tb/test_flash_host.sv */
`timescale 1ns/1ns
`default_nettype none
module test_flash_host;
   localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value.
   localparam logic [7:0] DEVID = 8'h3c; // Arbitrary value.
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic op_valid = 1'b0;
   logic [2:0] op_code = 3'h0;
   logic [18:0] op_addr = 19'h00000;
   logic [7:0] op_data = 8'h00;
   logic op_ready, rsp_valid, id_mode, suspended, chip_sel_n, out_en_n, write_n, byte_bus_oe_n;
   logic [18:0] addr_pins, a;
   logic [7:0] rsp_data, byte_bus_out, byte_bus_in, d;
   logic [7:0] exp_q[$];
   int fail_count = 0;
   int n_tests = 0;
   always #50 ref_clk = ~ref_clk;
   flash_host dut_u (.ref_clk, .rst_n, .clk_en, .op_valid, .op_ready, .op_code, .op_addr,
      .op_data, .rsp_valid, .rsp_data, .id_mode, .suspended, .chip_sel_n, .out_en_n,
      .write_n, .addr_pins, .byte_bus_out, .byte_bus_oe_n, .byte_bus_in);
   flash_device_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVID)) dev_u (.chip_sel_n,
      .out_en_n, .write_n, .addr_pins, .byte_bus_out, .byte_bus_in);
   task automatic finish_test;
      if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk_rsp(input logic [7:0] e);
      n_tests++;
      if (rsp_data !== e) begin
         fail_count++;
         $display("BAD rsp_data exp %h got %h", e, rsp_data);
      end
   endtask
   task automatic chk_flag(input string w, input logic s, input logic e);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s exp %b got %b", w, e, s);
      end
   endtask
   task automatic tick(inout int n);
      @(posedge ref_clk);
      #5;
      n++;
      if (n > 300) begin
         fail_count++;
         finish_test();
      end
   endtask
   // Issues one operation and waits until its answer is compared.
   task automatic do_op(input logic [2:0] c, input logic [18:0] ad, input logic [7:0] dt,
         input logic [7:0] e);
      int n;
      n = 0;
      while (op_ready !== 1'b1) tick(n);
      exp_q.push_back(e);
      op_code = c;
      op_addr = ad;
      op_data = dt;
      op_valid = 1'b1;
      tick(n);
      op_valid = 1'b0;
      while (exp_q.size() != 0) tick(n);
   endtask
   always @(negedge ref_clk) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) chk_flag("spurious answer", 1'b1, 1'b0);
         else chk_rsp(exp_q.pop_front());
      end
   end
   initial begin
      d = 8'($urandom(23998));
      repeat (20) @(posedge ref_clk);
      #5;
      rst_n = 1'b1;
      do_op(3'h0, 19'h12345, 8'h00, 8'hff);
      for (int i = 0; i < 3; i++) begin
         a = {3'h1, 16'($urandom)};
         d = 8'($urandom);
         fork
            do_op(3'h1, a, d, 8'h00);
            if (i == 1) begin
               repeat (4) @(posedge ref_clk);
               #5;
               clk_en = 1'b0;
               repeat (6) @(posedge ref_clk);
               #5;
               clk_en = 1'b1;
            end
         join
         do_op(3'h0, a, 8'h00, d);
      end
      do_op(3'h1, 19'h20010, 8'h00, 8'h00);
      do_op(3'h0, 19'h20010, 8'h00, 8'hff);
      do_op(3'h6, 19'h00000, 8'h00, MAKER);
      do_op(3'h6, 19'h00001, 8'h00, DEVID);
      do_op(3'h6, 19'h20002, 8'h00, 8'h01);
      do_op(3'h6, 19'h10002, 8'h00, 8'h00);
      chk_flag("id_mode", id_mode, 1'b1);
      do_op(3'h7, 19'h7ffff, 8'h00, 8'h00);
      chk_flag("id_mode", id_mode, 1'b0);
      do_op(3'h0, a, 8'h00, d);
      do_op(3'h3, 19'h10000, 8'h00, 8'h00);
      do_op(3'h0, a, 8'h00, 8'hff);
      do_op(3'h4, 19'h00000, 8'h00, 8'h00);
      chk_flag("suspended", suspended, 1'b1);
      do_op(3'h1, 19'h30040, 8'h5a, 8'h00);
      do_op(3'h0, 19'h30040, 8'h00, 8'h5a);
      do_op(3'h5, 19'h00000, 8'h00, 8'h00);
      chk_flag("suspended", suspended, 1'b0);
      do_op(3'h2, 19'h00000, 8'h00, 8'h00);
      do_op(3'h0, 19'h30040, 8'h00, 8'hff);
      rst_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      #5;
      rst_n = 1'b1;
      do_op(3'h0, 19'h30041, 8'h00, 8'hff);
      finish_test();
   end
endmodule // test_flash_host
`default_nettype wire
